//--- hw/fsp_host.sv
// Host controller that runs flash commands and polls status and protection state
// How it works
// [R1] After an error, only a read/reset command is sent to the device.
// [R2] Program inside erase suspend: complemented poll bit, toggling, error zero, busy low.
// [R3] Buffered program polling refers to the last buffer address loaded.
// [R4] Completion polling reads the programmed address or one inside the erasing block.
// [R5] Error bit or buffer-abort bit set means the operation failed.
// [R6] Status bits not defined for the operation are ignored.
// [R7] Normal program: complemented data, toggling, error/alt/abort zero, busy low.
// [R8] Erase: poll bit zero, toggle toggles, timer bit marks time-out, alt in erasing blocks.
// [R9] Erase suspend: erasing block polls one, steady toggle; others give array data.
// [R10] Lock register is 16-bit one-time programmable; bits 15..3 read as one.
// [R11] Password-mode lock bit 2 at zero means permanent password protection.
// [R12] Nonvolatile-mode lock bit 1 at zero keeps nonvolatile mode, kills password mode.
// [R13] Both mode lock bits may never be zero; such a program aborts.
// [R14] Lock bit 0 at zero protects the extended block; one leaves it open.
// [R15] Extended block protection is read in auto select mode.
// [R16] Block status reads 01h if either protection bit is zero, else 00h.
// [R17] Global lock bit zero freezes every nonvolatile protection bit.
// [R18] During program or erase the toggle bit inverts on every read.
module fsp_host
    import fsp_pkg::*;
(
    input  wire logic            clk,
    input  wire logic            sys_rst,
    input  wire logic            cmd_valid,
    output logic                 cmd_ready,
    input  fsp_cmd_t             cmd,
    output logic                 resp_valid,
    output fsp_resp_t            resp,
    output fsp_pins_t            flash_pins,
    input  wire logic [DQ_W-1:0] flash_dq_in,
    output logic                 flash_rst_n
);

    typedef struct packed {
        fsp_state_t        state;
        logic [7:0]        cnt;
        fsp_cmd_t          cmd;
        logic [3:0]        idx;
        logic [DQ_W-1:0]   first;
        logic [DQ_W-1:0]   rd_res;
        logic              phase;
        logic              retry;
        logic              fail;
        logic              err;
        logic              abort;
        logic              need_reset;
        logic              start;
        logic              bwr;
        logic [ADDR_W-1:0] baddr;
        logic [DQ_W-1:0]   bdata;
        logic              rst_n;
        logic              resp_valid;
        fsp_resp_t         resp;
    } fsp_host_t;

    fsp_host_t       s;
    fsp_host_t       next_s;
    logic            bus_done;
    logic [DQ_W-1:0] bus_rdata;
    fsp_step_t       step;
    logic            toggled;
    logic            err_seen;
    logic            abort_seen;
    logic            refuse;

    function automatic fsp_step_t mk(fsp_kind_t k, logic [ADDR_W-1:0] a, logic [DQ_W-1:0] d);
        fsp_step_t st;
        st = '{kind: k, a: a, d: d};
        return st;
    endfunction

    function automatic fsp_step_t unl(logic second);
        fsp_step_t st;
        st = second ? mk(K_WR, UNLOCK_A2, CMD_UNLOCK2) : mk(K_WR, UNLOCK_A1, CMD_UNLOCK1);
        return st;
    endfunction

    // Command sequences as a table of bus steps; K_END closes every one
    function automatic fsp_step_t seq(fsp_op_t op, logic [3:0] i,
                                      logic [ADDR_W-1:0] a, logic [DQ_W-1:0] d);
        fsp_step_t st;
        st = mk(K_END, '0, '0);
        unique case (op)
            OP_READ:  if (i == 4'h0) st = mk(K_RD, a, '0);
            OP_RESET: if (i == 4'h0) st = mk(K_WR, a, CMD_RESET);
            OP_PROGRAM: begin
                if (i < 4'h2) st = unl(i[0]);
                else if (i == 4'h2) st = mk(K_WR, UNLOCK_A1, CMD_PROGRAM);
                else if (i == 4'h3) st = mk(K_WR, a, d);
                else if (i == 4'h4) st = mk(K_POLL, a, '0); // R4
            end
            OP_BLOCK_ERASE, OP_CHIP_ERASE: begin
                if (i < 4'h2) st = unl(i[0]);
                else if (i == 4'h2) st = mk(K_WR, UNLOCK_A1, CMD_ERASE_SETUP);
                else if (i < 4'h5) st = unl(i == 4'h4);
                else if (i == 4'h5 && op == OP_CHIP_ERASE) st = mk(K_WR, UNLOCK_A1, CMD_CHIP_ERASE);
                else if (i == 4'h5) st = mk(K_WR, a, CMD_BLOCK_ERASE);
                else if (i == 4'h6) st = mk(K_POLL, a, '0); // R4
            end
            OP_PROT_STATUS: begin
                if (i < 4'h2) st = unl(i[0]);
                else if (i == 4'h2) st = mk(K_WR, UNLOCK_A1, CMD_AUTOSEL); // R15
                else if (i == 4'h3) st = mk(K_RD, a | PROT_STATUS_OFS, '0);
                else if (i == 4'h4) st = mk(K_WR, a, CMD_RESET);
            end
            OP_LOCK_READ, OP_LOCK_PROG: begin
                if (i < 4'h2) st = unl(i[0]);
                else if (i == 4'h2) st = mk(K_WR, UNLOCK_A1, CMD_LOCK_ENTER);
                else if (op == OP_LOCK_READ && i == 4'h3) st = mk(K_RD, LOCK_ADDR, '0);
                else if (op == OP_LOCK_READ && i == 4'h4) st = mk(K_WR, LOCK_ADDR, CMD_EXIT1);
                else if (op == OP_LOCK_READ && i == 4'h5) st = mk(K_WR, LOCK_ADDR, CMD_EXIT2);
                else if (op == OP_LOCK_PROG && i == 4'h3) st = mk(K_WR, LOCK_ADDR, CMD_PROGRAM);
                else if (op == OP_LOCK_PROG && i == 4'h4) st = mk(K_WR, LOCK_ADDR, d);
                else if (op == OP_LOCK_PROG && i == 4'h5) st = mk(K_POLL, LOCK_ADDR, '0);
                else if (op == OP_LOCK_PROG && i == 4'h6) st = mk(K_WR, LOCK_ADDR, CMD_EXIT1);
                else if (op == OP_LOCK_PROG && i == 4'h7) st = mk(K_WR, LOCK_ADDR, CMD_EXIT2);
            end
        endcase
        return st;
    endfunction

    fsp_bus_cycle i_fsp_bus_cycle (
        .clk     (clk),
        .sys_rst (sys_rst),
        .start   (s.start),
        .wr      (s.bwr),
        .addr    (s.baddr),
        .wdata   (s.bdata),
        .dq_in   (flash_dq_in),
        .pins    (flash_pins),
        .rdata   (bus_rdata),
        .done    (bus_done)
    );

    assign step       = seq(s.cmd.op, s.idx, s.cmd.addr, s.cmd.data);
    assign toggled    = s.first[BIT_TOGGLE] ^ bus_rdata[BIT_TOGGLE]; // R18
    assign err_seen   = bus_rdata[BIT_ERR]; // R5
    // Abort bit is only defined for program operations, so erase ignores it
    assign abort_seen = bus_rdata[BIT_ABORT] &&
                        (s.cmd.op == OP_PROGRAM || s.cmd.op == OP_LOCK_PROG); // R6
    // Refuse work after a failure until reset, and any lock write clearing both mode bits
    assign refuse = (s.need_reset && cmd.op != OP_RESET) || // R1
                    (cmd.op == OP_LOCK_PROG && !cmd.data[BIT_PW_LOCK] &&
                     !cmd.data[BIT_NV_LOCK]); // R13

    always_comb begin
        next_s = s;
        next_s.start      = 1'b0;
        next_s.resp_valid = 1'b0;
        unique case (s.state)
            S_RST: begin
                next_s.rst_n = 1'b0;
                if (s.cnt == CNT_RST_LOW - 8'h01) begin
                    next_s.rst_n = 1'b1;
                    next_s.cnt   = 8'h00;
                    next_s.state = S_REC;
                end else begin
                    next_s.cnt = s.cnt + 8'h01;
                end
            end
            S_REC: begin
                if (s.cnt == CNT_RST_REC - 8'h01) begin
                    next_s.state = S_IDLE;
                end else begin
                    next_s.cnt = s.cnt + 8'h01;
                end
            end
            S_IDLE: begin
                if (cmd_valid) begin
                    next_s.cmd   = cmd;
                    next_s.idx   = 4'h0;
                    next_s.fail  = refuse;
                    next_s.err   = 1'b0;
                    next_s.abort = 1'b0;
                    next_s.retry = 1'b0;
                    next_s.phase = 1'b0;
                    next_s.state = refuse ? S_RESP : S_ISSUE;
                    if (cmd.op == OP_RESET) begin
                        next_s.need_reset = 1'b0; // R1
                    end
                end
            end
            S_ISSUE: begin
                next_s.baddr = step.a;
                next_s.bdata = step.d;
                next_s.bwr   = (step.kind == K_WR);
                unique case (step.kind)
                    K_WR, K_RD: begin
                        next_s.start = 1'b1;
                        next_s.state = S_WAIT;
                    end
                    K_POLL: begin
                        next_s.start = 1'b1;
                        next_s.phase = 1'b0;
                        next_s.state = S_POLL;
                    end
                    K_END: next_s.state = S_RESP;
                endcase
            end
            S_WAIT: begin
                if (bus_done) begin
                    if (!s.bwr) begin
                        next_s.rd_res = bus_rdata;
                    end
                    next_s.idx   = s.idx + 4'h1;
                    next_s.state = S_ISSUE;
                end
            end
            S_POLL: begin
                // Reads come in pairs; a steady toggle bit means the device is done
                if (bus_done && !s.phase) begin
                    next_s.first = bus_rdata;
                    next_s.phase = 1'b1;
                    next_s.start = 1'b1;
                end else if (bus_done) begin
                    next_s.phase = 1'b0;
                    if (!toggled) begin
                        next_s.retry = 1'b0;
                        next_s.idx   = s.idx + 4'h1;
                        next_s.state = S_ISSUE;
                    end else if (s.retry) begin
                        next_s.fail       = 1'b1; // R5
                        next_s.need_reset = 1'b1; // R1
                        next_s.state      = S_RESP;
                    end else if (err_seen || abort_seen) begin
                        next_s.retry = 1'b1;
                        next_s.err   = err_seen;
                        next_s.abort = abort_seen;
                        next_s.start = 1'b1;
                    end else begin
                        next_s.start = 1'b1;
                    end
                end
            end
            S_RESP: begin
                next_s.resp_valid = 1'b1;
                next_s.resp.data  = s.rd_res;
                next_s.resp.err   = s.err && s.fail;
                next_s.resp.abort = s.abort && s.fail;
                next_s.resp.prot  = (s.cmd.op == OP_PROT_STATUS) &&
                                    (s.rd_res[7:0] == PROT_ON); // R16
                next_s.resp.fail  = s.fail || ((s.cmd.op == OP_LOCK_READ) &&
                                    !(&s.rd_res[DQ_W-1:LOCK_RSVD_LSB])); // R10
                next_s.state = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s <= '{state: S_RST, cnt: 8'h00, cmd: '{op: OP_READ, addr: '0, data: '0},
                   idx: 4'h0, first: '0, rd_res: '0, phase: 1'b0, retry: 1'b0,
                   fail: 1'b0, err: 1'b0, abort: 1'b0, need_reset: 1'b0, start: 1'b0,
                   bwr: 1'b0, baddr: '0, bdata: '0, rst_n: 1'b0, resp_valid: 1'b0,
                   resp: '0};
        end else begin
            s <= next_s;
        end
    end

    assign cmd_ready   = (s.state == S_IDLE);
    assign resp_valid  = s.resp_valid;
    assign resp        = s.resp;
    assign flash_rst_n = s.rst_n;

    AST_RESET_FIRST: assert property (@(posedge clk) disable iff (sys_rst) // R1
        (s.state == S_IDLE && cmd_valid && s.need_reset && cmd.op != OP_RESET)
        |=> (s.state == S_RESP && s.fail) ##1 (resp_valid && resp.fail))
        else $error("command accepted while a read/reset was owed");

    AST_NO_BUS_WHILE_OWED: assert property (@(posedge clk) disable iff (sys_rst) // R1
        (s.need_reset && s.cmd.op != OP_RESET && s.state != S_RESP) |-> !s.start)
        else $error("bus cycle started before the read/reset command");

    AST_POLL_ADDR: assert property (@(posedge clk) disable iff (sys_rst) // R4
        (s.state == S_POLL) |-> s.baddr ==
            ((s.cmd.op == OP_LOCK_PROG) ? LOCK_ADDR : s.cmd.addr))
        else $error("polling at an address outside the operation");

    AST_POLL_PIN_ADDR: assert property (@(posedge clk) disable iff (sys_rst) // R4
        (s.state == S_POLL && !flash_pins.oe_n) |-> flash_pins.addr == s.baddr)
        else $error("poll read drives the wrong address");

    AST_FAIL_REPORTED: assert property (@(posedge clk) disable iff (sys_rst) // R5
        (s.state == S_POLL && bus_done && s.phase && toggled && s.retry)
        |=> (s.state == S_RESP && s.need_reset) ##1 (resp_valid && resp.fail))
        else $error("error or abort status not reported as failure");

    AST_ABORT_IGNORED_ERASE: assert property (@(posedge clk) disable iff (sys_rst) // R6
        (resp_valid && (s.cmd.op == OP_BLOCK_ERASE || s.cmd.op == OP_CHIP_ERASE))
        |-> !resp.abort)
        else $error("abort bit used where it is undefined");

    AST_MODE_BITS_GUARD: assert property (@(posedge clk) disable iff (sys_rst) // R13
        (s.state == S_IDLE && cmd_valid && cmd.op == OP_LOCK_PROG &&
         !cmd.data[BIT_PW_LOCK] && !cmd.data[BIT_NV_LOCK])
        |=> s.state == S_RESP ##1 (resp_valid && resp.fail))
        else $error("lock write clearing both mode bits was not refused");

    AST_PROT_DECODE: assert property (@(posedge clk) disable iff (sys_rst) // R16
        (s.state == S_RESP && s.cmd.op == OP_PROT_STATUS && !s.fail)
        |=> resp_valid && resp.prot == (resp.data[7:0] == PROT_ON))
        else $error("protection status decoded wrongly");

endmodule

//--- inc/fsp_pkg.sv
// Shared constants, types and pin bundles for the flash status and protection host
package fsp_pkg;

    localparam int ADDR_W = 24;
    localparam int DQ_W   = 16;
    localparam int CLK_NS = 4;

    // Bus timing, in ns, and the derived cycle counts (least times round up)
    localparam int T_SETUP_NS   = 10;
    localparam int T_STROBE_NS  = 70;
    localparam int T_HOLD_NS    = 30;
    localparam int T_RST_LOW_NS = 500;
    localparam int T_RST_REC_NS = 50;
    localparam logic [7:0] CNT_SETUP   = 8'((T_SETUP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] CNT_STROBE  = 8'((T_STROBE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] CNT_HOLD    = 8'((T_HOLD_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] CNT_RST_LOW = 8'((T_RST_LOW_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] CNT_RST_REC = 8'((T_RST_REC_NS + CLK_NS - 1) / CLK_NS);

    // Command cycle addresses and data
    localparam logic [ADDR_W-1:0] UNLOCK_A1       = 24'h000555;
    localparam logic [ADDR_W-1:0] UNLOCK_A2       = 24'h0002aa;
    localparam logic [ADDR_W-1:0] LOCK_ADDR       = 24'h000000;
    localparam logic [ADDR_W-1:0] PROT_STATUS_OFS = 24'h000002;
    localparam logic [DQ_W-1:0]   CMD_UNLOCK1     = 16'h00aa;
    localparam logic [DQ_W-1:0]   CMD_UNLOCK2     = 16'h0055;
    localparam logic [DQ_W-1:0]   CMD_PROGRAM     = 16'h00a0;
    localparam logic [DQ_W-1:0]   CMD_ERASE_SETUP = 16'h0080;
    localparam logic [DQ_W-1:0]   CMD_CHIP_ERASE  = 16'h0010;
    localparam logic [DQ_W-1:0]   CMD_BLOCK_ERASE = 16'h0030;
    localparam logic [DQ_W-1:0]   CMD_RESET       = 16'h00f0;
    localparam logic [DQ_W-1:0]   CMD_AUTOSEL     = 16'h0090;
    localparam logic [DQ_W-1:0]   CMD_LOCK_ENTER  = 16'h0040;
    localparam logic [DQ_W-1:0]   CMD_EXIT1       = 16'h0090;
    localparam logic [DQ_W-1:0]   CMD_EXIT2       = 16'h0000;

    // Status and lock bit positions
    localparam int BIT_POLL    = 7;
    localparam int BIT_TOGGLE  = 6;
    localparam int BIT_ERR     = 5;
    localparam int BIT_ABORT   = 1;
    localparam int BIT_PW_LOCK = 2;
    localparam int BIT_NV_LOCK = 1;
    localparam int LOCK_RSVD_LSB = 3;
    localparam logic [7:0] PROT_ON = 8'h01;

    typedef enum logic [2:0] {
        OP_READ, OP_RESET, OP_PROGRAM, OP_BLOCK_ERASE,
        OP_CHIP_ERASE, OP_PROT_STATUS, OP_LOCK_READ, OP_LOCK_PROG
    } fsp_op_t;

    typedef enum logic [1:0] {K_WR, K_RD, K_POLL, K_END} fsp_kind_t;
    typedef enum {S_RST, S_REC, S_IDLE, S_ISSUE, S_WAIT, S_POLL, S_RESP} fsp_state_t;
    typedef enum {B_IDLE, B_SETUP, B_STROBE, B_HOLD} fsp_bstate_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DQ_W-1:0]   dq_out;
        logic              dq_oe_n;
        logic              ce_n;
        logic              oe_n;
        logic              we_n;
    } fsp_pins_t;

    typedef struct packed {
        fsp_op_t           op;
        logic [ADDR_W-1:0] addr;
        logic [DQ_W-1:0]   data;
    } fsp_cmd_t;

    typedef struct packed {
        logic [DQ_W-1:0] data;
        logic            fail;
        logic            err;
        logic            abort;
        logic            prot;
    } fsp_resp_t;

    typedef struct packed {
        fsp_kind_t         kind;
        logic [ADDR_W-1:0] a;
        logic [DQ_W-1:0]   d;
    } fsp_step_t;

endpackage

//--- hw/fsp_bus_cycle.sv
// One asynchronous read or write cycle on the flash pins
module fsp_bus_cycle
    import fsp_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic              start,
    input  wire logic              wr,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DQ_W-1:0]   wdata,
    input  wire logic [DQ_W-1:0]   dq_in,
    output fsp_pins_t              pins,
    output logic [DQ_W-1:0]        rdata,
    output logic                   done
);

    typedef struct packed {
        fsp_bstate_t     st;
        logic [7:0]      cnt;
        fsp_pins_t       pins;
        logic [DQ_W-1:0] rdata;
        logic            done;
        logic            wr;
    } fsp_bus_t;

    localparam fsp_pins_t PINS_IDLE = '{addr: '0, dq_out: '0, dq_oe_n: 1'b1,
                                        ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};

    fsp_bus_t s;
    fsp_bus_t next_s;

    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        unique case (s.st)
            B_IDLE: begin
                if (start) begin
                    next_s.pins.addr    = addr;
                    next_s.pins.dq_out  = wdata;
                    next_s.pins.dq_oe_n = !wr;
                    next_s.pins.ce_n    = 1'b0;
                    next_s.wr           = wr;
                    next_s.cnt          = CNT_SETUP - 8'h01;
                    next_s.st           = B_SETUP;
                end
            end
            B_SETUP: begin
                if (s.cnt == 8'h00) begin
                    next_s.pins.we_n = !s.wr;
                    next_s.pins.oe_n = s.wr;
                    next_s.cnt       = CNT_STROBE - 8'h01;
                    next_s.st        = B_STROBE;
                end else begin
                    next_s.cnt = s.cnt - 8'h01;
                end
            end
            B_STROBE: begin
                if (s.cnt == 8'h00) begin
                    // Sampled on the last strobe cycle, after the full access time
                    if (!s.wr) begin
                        next_s.rdata = dq_in;
                    end
                    next_s.pins.we_n = 1'b1;
                    next_s.pins.oe_n = 1'b1;
                    next_s.cnt       = CNT_HOLD - 8'h01;
                    next_s.st        = B_HOLD;
                end else begin
                    next_s.cnt = s.cnt - 8'h01;
                end
            end
            B_HOLD: begin
                // Data stays driven past the write strobe's rising edge
                if (s.cnt == 8'h00) begin
                    next_s.pins.ce_n    = 1'b1;
                    next_s.pins.dq_oe_n = 1'b1;
                    next_s.done         = 1'b1;
                    next_s.st           = B_IDLE;
                end else begin
                    next_s.cnt = s.cnt - 8'h01;
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s <= '{st: B_IDLE, cnt: 8'h00, pins: PINS_IDLE, rdata: '0, done: 1'b0, wr: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    assign pins  = s.pins;
    assign rdata = s.rdata;
    assign done  = s.done;

    AST_WRITE_DATA_HELD: assert property (@(posedge clk) disable iff (sys_rst)
        $fell(pins.we_n) |-> (!pins.we_n && !pins.dq_oe_n && !pins.ce_n) [*8])
        else $error("write strobe shorter than expected or data not driven");

endmodule

//--- sim/fsp_flash_model.sv
// Behavioural flash device: status polling, auto select and lock register
module fsp_flash_model
    import fsp_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  fsp_pins_t       pins,
    input  wire logic       vp,
    input  wire logic       nvp,
    input  wire logic [1:0] inject,
    output logic [DQ_W-1:0] dq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [DQ_W-1:0] mem, lastw, lockr, rd, last, d;
    logic [1:0]      mode;
    logic [2:0]      busy;
    logic            tog, err, abt, era, we_q, oe_q, pend;
    initial lockr = 16'hffff;
    initial mem = 16'hffff;
    assign d = pins.dq_out;
    assign pend = busy != 3'h0 || err || abt;
    always_comb begin
        // Same status picture whether or not an erase is suspended; poll bit is the inverse of bit 7 of the last word, zero in erase
        if (pend)
            rd = {8'h00, ~era & ~mem[7], tog, err, 1'b0, era, era & tog, abt, 1'b0};
        // Protection bits are fixed bench inputs, as under a global lock bit at zero
        else if (mode == 2'h2)
            rd = {15'h0000, ~(vp & nvp)};
        else if (mode == 2'h1)
            rd = {13'h1fff, lockr[2:0]};
        else
            rd = mem;
    end
    // No pull on DQ: a released bus shows the inverse of the last word the device drove
    assign dq = (!pins.ce_n && !pins.oe_n && rst_n) ? rd : ~last;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {mode, busy, err, abt, era, tog, lastw, last} <= '0;
            {we_q, oe_q} <= 2'b11;
        end else begin
            we_q <= pins.we_n;
            oe_q <= pins.oe_n;
            if (!pins.ce_n && !pins.oe_n)
                last <= rd;
            if (pins.oe_n && !oe_q && pend) begin
                tog <= ~tog;
                if (!err && !abt)
                    busy <= busy - 3'h1;
            end
            if (pins.we_n && !we_q) begin
                lastw <= (lastw == CMD_PROGRAM) ? 16'h0000 : d;
                if (d == CMD_RESET)
                    {mode, busy, err, abt} <= '0;
                else if (pend)
                    lastw <= lastw;
                else if (lastw == CMD_PROGRAM && mode == 2'h1) begin
                    if (~d[2] & ~lockr[1] | ~d[1] & ~lockr[2])
                        mode <= 2'h0;
                    else
                        lockr <= lockr & d;
                end else if (lastw == CMD_PROGRAM) begin
                    mem <= d;
                    busy <= 3'h3;
                    {abt, err} <= inject;
                    era <= 1'b0;
                end else if (d == CMD_LOCK_ENTER)
                    mode <= 2'h1;
                else if (d == CMD_AUTOSEL)
                    mode <= (mode == 2'h1) ? 2'h0 : 2'h2;
                else if (lastw == CMD_UNLOCK2 && (d == CMD_BLOCK_ERASE || d == CMD_CHIP_ERASE)) begin
                    busy <= 3'h4;
                    era <= 1'b1;
                    mem <= 16'hffff;
                end
            end
        end
    end
endmodule

//--- sim/fsp_host_tb_top.sv
// Self-checking bench for the flash status and protection host
module fsp_host_tb_top
    import fsp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic              clk = 1'b0, sys_rst = 1'b1, cmd_valid = 1'b0;
    logic              vp = 1'b1, nvp = 1'b1;
    logic [1:0]        inject = 2'b00;
    logic              cmd_ready, resp_valid, flash_rst_n, ok;
    fsp_cmd_t          cmd;
    fsp_resp_t         resp, e;
    fsp_pins_t         pins;
    logic [DQ_W-1:0]   dq, mdq, w;
    logic [ADDR_W-1:0] a = 24'h000000;
    int                bad_count = 0, compares = 0;
    integer            seed = 32'ha04872f3;
    fsp_resp_t         exp_q[$];
    logic              chk_q[$];
    always #2 clk = ~clk;
    assign dq = pins.dq_oe_n ? mdq : pins.dq_out;
    fsp_host i_fsp_host (.clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd(cmd), .resp_valid(resp_valid), .resp(resp),
        .flash_pins(pins), .flash_dq_in(dq), .flash_rst_n(flash_rst_n));
    fsp_flash_model i_fsp_flash_model (.clk(clk), .rst_n(flash_rst_n), .pins(pins),
        .vp(vp), .nvp(nvp), .inject(inject), .dq(mdq));
    task automatic summarize;
        // A response still owed at the end counts as a miss
        bad_count += exp_q.size();
        $display("mismatches %0d compares %0d", bad_count, compares);
        if (bad_count == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic cmp(input logic [DQ_W-1:0] got, input logic [DQ_W-1:0] ex);
        compares++;
        if (got !== ex) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, ex);
        end
    endtask
    // Request held from a falling edge until the rising edge that takes it
    task automatic run(input fsp_op_t op, input logic [DQ_W-1:0] dt, input logic fl,
                       input logic [DQ_W-1:0] xd, input logic ck);
        @(negedge clk);
        cmd = '{op, a, dt};
        cmd_valid = 1'b1;
        exp_q.push_back('{xd, fl, fl & inject[0], fl & inject[1], op == OP_PROT_STATUS && xd[0]});
        chk_q.push_back(ck);
        while (cmd_ready !== 1'b1)
            @(negedge clk);
        @(negedge clk);
        cmd_valid = 1'b0;
        while (cmd_ready !== 1'b1)
            @(negedge clk);
    endtask
    always @(negedge clk) begin
        if (resp_valid === 1'b1 && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            ok = chk_q.pop_front();
            cmp(16'(resp.fail), 16'(e.fail));
            cmp(16'(resp.prot), 16'(e.prot));
            cmp(16'({resp.err, resp.abort}), 16'({e.err, e.abort}));
            if (ok)
                cmp(resp.data, e.data);
        end
    end
    initial begin
        cmd = '0;
        repeat (4) @(posedge clk);
        @(negedge clk);
        sys_rst = 1'b0;
        for (int i = 0; i < 4; i++) begin
            {vp, nvp} = 2'(i);
            a = 24'($random(seed));
            run(OP_PROT_STATUS, 16'h0000, 1'b0, {15'h0000, i != 3}, 1'b1);
        end
        run(OP_LOCK_READ, 16'h0000, 1'b0, 16'hffff, 1'b1);
        w = 16'($random(seed));
        run(OP_PROGRAM, w, 1'b0, 16'h0000, 1'b0);
        run(OP_READ, 16'h0000, 1'b0, w, 1'b1);
        run(OP_BLOCK_ERASE, 16'h0000, 1'b0, 16'h0000, 1'b0);
        run(OP_READ, 16'h0000, 1'b0, 16'hffff, 1'b1);
        run(OP_CHIP_ERASE, 16'h0000, 1'b0, 16'h0000, 1'b0);
        run(OP_LOCK_PROG, 16'hfff9, 1'b1, 16'h0000, 1'b0);
        run(OP_LOCK_PROG, 16'hfffa, 1'b0, 16'h0000, 1'b0);
        run(OP_LOCK_PROG, 16'hfffd, 1'b0, 16'h0000, 1'b0);
        run(OP_LOCK_READ, 16'h0000, 1'b0, 16'hfffa, 1'b1);
        inject = 2'b01;
        run(OP_PROGRAM, ~w, 1'b1, 16'h0000, 1'b0);
        inject = 2'b00;
        run(OP_READ, 16'h0000, 1'b1, 16'h0000, 1'b0);
        run(OP_RESET, 16'h0000, 1'b0, 16'h0000, 1'b0);
        run(OP_READ, 16'h0000, 1'b0, ~w, 1'b1);
        inject = 2'b10;
        run(OP_PROGRAM, w, 1'b1, 16'h0000, 1'b0);
        inject = 2'b00;
        run(OP_RESET, 16'h0000, 1'b0, 16'h0000, 1'b0);
        repeat (4) @(negedge clk);
        summarize();
    end
    initial begin
        #240000;
        bad_count++;
        summarize();
    end
endmodule
